// File: iss_pkg.sv
package iss_pkg;

	localparam int CLK_HZ     = 40_000_000;
	localparam int NCH        = 28;
	localparam int QW         = 16;
	localparam int ERRQ_DEPTH = 15;
	localparam int RATE_19200 = 19200;
	localparam int RATE_9600  = 9600;
	localparam int RATE_4800  = 4800;
	localparam int RATE_2400  = 2400;
	localparam logic [15:0] DIV_19200 = 16'(CLK_HZ / RATE_19200);
	localparam logic [15:0] DIV_9600  = 16'(CLK_HZ / RATE_9600);
	localparam logic [15:0] DIV_4800  = 16'(CLK_HZ / RATE_4800);
	localparam logic [15:0] DIV_2400  = 16'(CLK_HZ / RATE_2400);

	localparam logic [7:0] A_CTRL     = 8'h00;
	localparam logic [7:0] A_MULTI    = 8'h04;
	localparam logic [7:0] A_GPIB     = 8'h08;
	localparam logic [7:0] A_BAUD     = 8'h0c;
	localparam logic [7:0] A_CHSEL    = 8'h10;
	localparam logic [7:0] A_INST1_EN = 8'h14;
	localparam logic [7:0] A_SECOND_CHANNEL_GROUP_SUMMARY_EN = 8'h18;
	localparam logic [7:0] A_ISUM_EN  = 8'h1c;
	localparam logic [7:0] A_ISUM     = 8'h20;
	localparam logic [7:0] A_INST1    = 8'h24;
	localparam logic [7:0] A_SECOND_CHANNEL_GROUP_SUMMARY    = 8'h28;
	localparam logic [7:0] A_ERR      = 8'h2c;
	localparam logic [7:0] A_VERS     = 8'h30;
	localparam logic [7:0] A_LANG     = 8'h34;
	localparam logic [7:0] A_LANG_RET = 8'h38;
	localparam logic [7:0] A_QUERY    = 8'h3c;
	localparam logic [7:0] A_CMD_DONE = 8'h40;
	localparam logic [7:0] A_SOFT_RST = 8'h44;
	localparam logic [7:0] A_IRQ_STAT = 8'h48;
	localparam logic [7:0] A_IRQ_CLR  = 8'h4c;
	localparam logic [7:0] A_IRQ_EN   = 8'h50;

	// control register fields
	localparam int F_FLOW   = 0;
	localparam int F_PROMPT = 1;
	localparam int F_ECHO   = 2;
	localparam int F_COMPAT = 3;

	localparam logic [4:0]  GPIB_MIN   = 5'h01;
	localparam logic [4:0]  GPIB_MAX   = 5'h1e;
	localparam logic [4:0]  GPIB_RST   = 5'h06;
	localparam logic [15:0] ERR_NONE   = 16'h0000;
	localparam logic [15:0] ERR_CMD    = 16'hff9c;
	localparam logic [15:0] ERR_RANGE  = 16'hff22;
	localparam logic [15:0] ERR_PARAM  = 16'hff20;
	localparam logic [15:0] ERR_OVF    = 16'hfea2;
	localparam logic [15:0] VERS_YEAR  = 16'h07cd;
	localparam logic [15:0] VERS_REV   = 16'h0000;
	localparam logic [31:0] LANG_WORD  = 32'h53435049;
	localparam logic [7:0]  CH_PROMPT  = 8'h3e;
	localparam logic [7:0]  CH_TERM    = 8'h0a;
	localparam logic [7:0]  CH_ZERO    = 8'h30;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} iss_wb_req_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} iss_char_t;

	typedef enum logic [1:0] {TX_IDLE, TX_CONV, TX_DIG, TX_TERM} iss_tx_state_t;

endpackage

// File: iss_top.sv
// The implementer's own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module iss_top
	import iss_pkg::*;
#(
	parameter int DEPTH = ERRQ_DEPTH
)(
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire iss_wb_req_t              wb_req_i,
	output logic        [31:0]            wb_dat_o,
	output logic                          wb_ack_o,
	input  wire logic   [NCH-1:0][QW-1:0] ques_evt_i,
	input  wire iss_char_t                rx_i,
	output iss_char_t                     tx_o,
	input  wire logic                     tx_ready_i,
	output logic        [15:0]            baud_div_o,
	output logic                          flow_xon_o,
	output logic                          echo_on_o,
	output logic                          compat_o,
	output logic                          multi_inst_o,
	output logic                          legacy_lang_o,
	output logic        [4:0]             gpib_addr_o,
	output logic                          irq_o
);

	////////////////////////////////////////////////////////////////////////
	logic        [3:0]  ctrl_q;
	logic               multi_q;
	logic               legacy_q;
	logic        [4:0]  gpib_q;
	logic        [15:0] baud_q;
	logic        [15:0] div_q;
	logic        [4:0]  chsel_q;
	logic        [15:0] inst1_en_q;
	logic        [15:0] second_channel_group_summary_en_q;
	logic [NCH-1:0][QW-1:0] isum_q;
	logic [NCH-1:0][QW-1:0] isum_en_q;
	logic        [15:0] inst1_q;
	logic        [15:0] second_channel_group_summary_q;
	logic        [15:0] errq_q [DEPTH];
	logic        [3:0]  wp_q;
	logic        [3:0]  rp_q;
	logic        [4:0]  cnt_q;
	logic        [2:0]  stat_q;
	logic        [2:0]  irq_en_q;
	logic               ack_q;
	logic        [31:0] dat_q;
	logic               irq_q;
	logic               echo_act_q;
	logic               echo_pend_q;
	logic        [7:0]  echo_ch_q;
	logic               prompt_pend_q;
	logic               fmt_pend_q;
	logic        [15:0] fmt_val_q;
	iss_tx_state_t      tx_st_q;
	logic        [15:0] rem_q;
	logic        [2:0]  pidx_q;
	logic        [3:0]  digit_q;
	logic               started_q;
	iss_char_t          tx_q;

	logic               req;
	logic               wr;
	logic               rd;
	logic        [7:0]  adr;
	logic        [31:0] wdat;
	logic               std_ok;
	logic               isum_acc;
	logic               push;
	logic        [15:0] push_code;
	logic               pop;
	logic               soft_rst;
	logic        [4:0]  ch_idx;
	logic [NCH-1:0]     ch_hit;
	logic        [15:0] inst1_set;
	logic        [15:0] second_channel_group_summary_set;
	logic        [2:0]  stat_ev;
	logic        [15:0] pow;

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] m;
		m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		return (old & ~m) | (d & m);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// bus decode; side effects happen only on the edge that raises ack
	assign req      = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
	assign adr      = wb_req_i.adr;
	assign wdat     = wmerge(32'h0000_0000, wb_req_i.dat, wb_req_i.sel);
	assign std_ok   = ~legacy_q | (adr == A_LANG_RET) | (adr == A_LANG)
		| (adr == A_IRQ_STAT) | (adr == A_IRQ_CLR) | (adr == A_IRQ_EN);
	assign wr       = req & wb_req_i.we & std_ok;
	assign rd       = req & ~wb_req_i.we & std_ok;
	assign isum_acc = (adr == A_ISUM) | (adr == A_ISUM_EN);
	assign soft_rst = wr & (adr == A_SOFT_RST);
	assign ch_idx   = (chsel_q == 5'h00) ? 5'h00 : chsel_q - 5'h01;
	assign pop      = rd & (adr == A_ERR) & (cnt_q != 5'h00);

	always_comb
	begin
		push      = 1'b0;
		push_code = ERR_NONE;
		if (req & ~std_ok & wb_req_i.we)
		begin
			push      = 1'b1;
			push_code = ERR_CMD;
		end
		else if ((wr | rd) & isum_acc & ~multi_q)
		begin
			push      = 1'b1;
			push_code = ERR_CMD;
		end
		else if (wr & (adr == A_GPIB)
			& ((wdat[4:0] < GPIB_MIN) | (wdat[4:0] > GPIB_MAX) | (wdat[31:5] != 27'h0)))
		begin
			push      = 1'b1;
			push_code = ERR_RANGE;
		end
		else if (wr & (adr == A_BAUD) & (wdat[15:0] != 16'(RATE_19200))
			& (wdat[15:0] != 16'(RATE_9600)) & (wdat[15:0] != 16'(RATE_4800))
			& (wdat[15:0] != 16'(RATE_2400)))
		begin
			push      = 1'b1;
			push_code = ERR_PARAM;
		end
		else if (wr & (adr == A_ERR))
		begin
			push      = 1'b1;
			push_code = wdat[15:0];
		end
	end

	function automatic logic [31:0] peek(input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (a)
			A_CTRL:     v = {28'h0, ctrl_q};
			A_MULTI:    v = {31'h0, multi_q};
			A_GPIB:     v = {27'h0, gpib_q};
			A_BAUD:     v = {16'h0, baud_q};
			A_CHSEL:    v = {27'h0, chsel_q};
			A_INST1_EN: v = {16'h0, inst1_en_q};
			A_SECOND_CHANNEL_GROUP_SUMMARY_EN: v = {16'h0, second_channel_group_summary_en_q};
			A_ISUM_EN:  v = {16'h0, isum_en_q[ch_idx]};
			A_ISUM:     v = {16'h0, isum_q[ch_idx]};
			A_INST1:    v = {16'h0, inst1_q};
			A_SECOND_CHANNEL_GROUP_SUMMARY:    v = {16'h0, second_channel_group_summary_q};
			A_ERR:      v = (cnt_q == 5'h00) ? 32'h0000_0000
				: {{16{errq_q[rp_q][15]}}, errq_q[rp_q]};
			A_VERS:     v = {VERS_YEAR, VERS_REV};
			A_LANG:     v = {31'h0, legacy_q};
			A_IRQ_STAT: v = {29'h0, stat_q};
			A_IRQ_EN:   v = {29'h0, irq_en_q};
			default:    v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end
		else
		begin
			ack_q <= req;
			dat_q <= (rd & ~(isum_acc & ~multi_q)) ? peek(adr) : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// settings
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_q   <= 4'h0;
			multi_q  <= 1'b0;
			legacy_q <= 1'b0;
			gpib_q   <= GPIB_RST;
			baud_q   <= 16'(RATE_9600);
			div_q    <= DIV_9600;
			chsel_q  <= 5'h01;
		end
		else
		begin
			if (wr & (adr == A_CTRL))
				ctrl_q <= 4'(wmerge({28'h0, ctrl_q}, wb_req_i.dat, wb_req_i.sel));
			else if (soft_rst)
				ctrl_q <= ctrl_q & (4'h1 << F_ECHO);
			if (wr & (adr == A_MULTI))
				multi_q <= wdat[0];
			if (wr & (adr == A_LANG) & wdat[0])
				legacy_q <= 1'b1;
			else if (wr & (adr == A_LANG_RET) & (wdat == LANG_WORD))
				legacy_q <= 1'b0;
			if (wr & (adr == A_GPIB) & ~push)
				gpib_q <= wdat[4:0];
			if (wr & (adr == A_BAUD) & ~push)
			begin
				baud_q <= wdat[15:0];
				unique case (wdat[15:0])
					16'(RATE_19200): div_q <= DIV_19200;
					16'(RATE_4800):  div_q <= DIV_4800;
					16'(RATE_2400):  div_q <= DIV_2400;
					default:         div_q <= DIV_9600;
				endcase
			end
			if (wr & (adr == A_CHSEL) & (wdat[4:0] != 5'h00) & (wdat[4:0] <= 5'(NCH)))
				chsel_q <= wdat[4:0];
			else if (soft_rst)
				chsel_q <= 5'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// channel summaries; a new event wins over the read that clears
	generate
		for (genvar c = 0; c < NCH; c++)
		begin : g_ch
			always_ff @(posedge clk_i)
			begin
				if (rst_i | soft_rst)
				begin
					isum_q[c]    <= '0;
					isum_en_q[c] <= '0;
				end
				else
				begin
					if (wr & (adr == A_ISUM_EN) & multi_q & (ch_idx == 5'(c)))
						isum_en_q[c] <= wdat[QW-1:0];
					isum_q[c] <= ((rd & (adr == A_ISUM) & multi_q & (ch_idx == 5'(c)))
						? '0 : isum_q[c]) | (ques_evt_i[c] & isum_en_q[c]);
				end
			end
			assign ch_hit[c] = |isum_q[c];
		end
	endgenerate

	assign second_channel_group_summary_set = {1'b0, ch_hit[NCH-1:14] & second_channel_group_summary_en_q[14:1], 1'b0};
	assign inst1_set = {1'b0, ch_hit[13:0] & inst1_en_q[14:1],
		(|second_channel_group_summary_q) & inst1_en_q[0]};

	always_ff @(posedge clk_i)
	begin
		if (rst_i | soft_rst)
		begin
			inst1_en_q <= 16'h0000;
			second_channel_group_summary_en_q <= 16'h0000;
			inst1_q    <= 16'h0000;
			second_channel_group_summary_q    <= 16'h0000;
		end
		else
		begin
			if (wr & (adr == A_INST1_EN))
				inst1_en_q <= 16'(wmerge({16'h0, inst1_en_q}, wb_req_i.dat, wb_req_i.sel));
			if (wr & (adr == A_SECOND_CHANNEL_GROUP_SUMMARY_EN))
				second_channel_group_summary_en_q <= 16'(wmerge({16'h0, second_channel_group_summary_en_q}, wb_req_i.dat, wb_req_i.sel));
			inst1_q <= ((rd & (adr == A_INST1)) ? 16'h0000 : inst1_q) | inst1_set;
			second_channel_group_summary_q <= ((rd & (adr == A_SECOND_CHANNEL_GROUP_SUMMARY)) ? 16'h0000 : second_channel_group_summary_q) | second_channel_group_summary_set;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// error queue; pushes come from writes and from single-mode A_ISUM/A_ISUM_EN reads, pops only from A_ERR reads,
	// so the two never meet in one cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wp_q  <= 4'h0;
			rp_q  <= 4'h0;
			cnt_q <= 5'h00;
		end
		else if (push & (cnt_q < 5'(DEPTH)))
		begin
			errq_q[wp_q] <= (cnt_q == 5'(DEPTH - 1)) ? ERR_OVF : push_code;
			wp_q         <= (wp_q == 4'(DEPTH - 1)) ? 4'h0 : wp_q + 4'h1;
			cnt_q        <= cnt_q + 5'h01;
		end
		else if (pop)
		begin
			rp_q  <= (rp_q == 4'(DEPTH - 1)) ? 4'h0 : rp_q + 4'h1;
			cnt_q <= cnt_q - 5'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupts: queued error, overflow, new summary bit
	assign stat_ev = {(|inst1_set) | (|second_channel_group_summary_set),
		push & (cnt_q == 5'(DEPTH - 1)), push & (cnt_q < 5'(DEPTH))};

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			stat_q   <= 3'h0;
			irq_en_q <= 3'h0;
			irq_q    <= 1'b0;
		end
		else
		begin
			stat_q <= (stat_q & ~((wr & (adr == A_IRQ_CLR)) ? wdat[2:0] : 3'h0)) | stat_ev;
			if (wr & (adr == A_IRQ_EN))
				irq_en_q <= wdat[2:0];
			irq_q <= |(stat_q & irq_en_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// echo and prompt requests
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			echo_act_q    <= 1'b0;
			echo_pend_q   <= 1'b0;
			echo_ch_q     <= 8'h00;
			prompt_pend_q <= 1'b0;
		end
		else
		begin
			if (ctrl_q[F_ECHO])
				echo_act_q <= 1'b1;
			else if (rx_i.valid & (rx_i.data == CH_TERM))
				echo_act_q <= 1'b0;
			// a character arriving while one still waits replaces it
			if (rx_i.valid & echo_act_q)
			begin
				echo_pend_q <= 1'b1;
				echo_ch_q   <= rx_i.data;
			end
			else if ((tx_st_q == TX_IDLE) & ~tx_q.valid & ~fmt_pend_q)
				echo_pend_q <= 1'b0;
			if (wr & (adr == A_CMD_DONE) & ctrl_q[F_PROMPT])
				prompt_pend_q <= 1'b1;
			else if ((tx_st_q == TX_IDLE) & ~tx_q.valid & ~fmt_pend_q & ~echo_pend_q)
				prompt_pend_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// decimal formatter and character sender
	always_comb
	begin
		unique case (pidx_q)
			3'd0:    pow = 16'h2710;
			3'd1:    pow = 16'h03e8;
			3'd2:    pow = 16'h0064;
			3'd3:    pow = 16'h000a;
			default: pow = 16'h0001;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			fmt_pend_q <= 1'b0;
			fmt_val_q  <= 16'h0000;
		end
		else if (wr & (adr == A_QUERY))
		begin
			fmt_pend_q <= 1'b1;
			fmt_val_q  <= 16'(peek(wdat[7:0]));
		end
		else if ((tx_st_q == TX_IDLE) & ~tx_q.valid)
			fmt_pend_q <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tx_st_q   <= TX_IDLE;
			tx_q      <= '0;
			rem_q     <= 16'h0000;
			pidx_q    <= 3'd0;
			digit_q   <= 4'h0;
			started_q <= 1'b0;
		end
		else
		begin
			if (tx_q.valid & tx_ready_i)
				tx_q.valid <= 1'b0;
			unique case (tx_st_q)
				TX_IDLE:
					if (~tx_q.valid)
					begin
						if (fmt_pend_q)
						begin
							tx_st_q   <= TX_CONV;
							rem_q     <= fmt_val_q;
							pidx_q    <= 3'd0;
							digit_q   <= 4'h0;
							started_q <= 1'b0;
						end
						else if (echo_pend_q)
							tx_q <= '{valid: 1'b1, data: echo_ch_q};
						else if (prompt_pend_q)
							tx_q <= '{valid: 1'b1, data: CH_PROMPT};
					end
				TX_CONV:
					if (rem_q >= pow)
					begin
						rem_q   <= rem_q - pow;
						digit_q <= digit_q + 4'h1;
					end
					else if ((digit_q != 4'h0) | started_q | (pidx_q == 3'd4))
					begin
						tx_q      <= '{valid: 1'b1, data: CH_ZERO + {4'h0, digit_q}};
						started_q <= 1'b1;
						tx_st_q   <= TX_DIG;
					end
					else
						pidx_q <= pidx_q + 3'd1;
				TX_DIG:
					if (tx_ready_i)
					begin
						digit_q <= 4'h0;
						if (pidx_q == 3'd4)
						begin
							tx_q    <= '{valid: 1'b1, data: CH_TERM};
							tx_st_q <= TX_TERM;
						end
						else
						begin
							pidx_q  <= pidx_q + 3'd1;
							tx_st_q <= TX_CONV;
						end
					end
				TX_TERM:
					if (tx_ready_i)
						tx_st_q <= TX_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign wb_ack_o      = ack_q;
	assign wb_dat_o      = dat_q;
	assign tx_o          = tx_q;
	assign baud_div_o    = div_q;
	assign flow_xon_o    = ctrl_q[F_FLOW];
	assign echo_on_o     = echo_act_q;
	assign compat_o      = ctrl_q[F_COMPAT];
	assign multi_inst_o  = multi_q;
	assign legacy_lang_o = legacy_q;
	assign gpib_addr_o   = gpib_q;
	assign irq_o         = irq_q;

	////////////////////////////////////////////////////////////////////////
	sequence s_ovf_push;
		push && cnt_q == 5'(DEPTH - 1);
	endsequence
	sequence s_prompt_req;
		wr && adr == A_CMD_DONE && ctrl_q[F_PROMPT] && tx_st_q == TX_IDLE && !tx_q.valid
			&& !fmt_pend_q && !echo_pend_q && tx_ready_i;
	endsequence

	property p_ack_once;
		@(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

	property p_gpib_range;
		@(posedge clk_i) disable iff (rst_i) gpib_addr_o >= GPIB_MIN && gpib_addr_o <= GPIB_MAX;
	endproperty
	a_gpib_range: assert property (p_gpib_range) else $error("bus address out of range");

	property p_ovf_last;
		@(posedge clk_i) disable iff (rst_i)
			s_ovf_push |=> errq_q[$past(wp_q)] == ERR_OVF && cnt_q == 5'(DEPTH);
	endproperty
	a_ovf_last: assert property (p_ovf_last) else $error("overflow entry missing");

	property p_full_drop;
		@(posedge clk_i) disable iff (rst_i) push && cnt_q == 5'(DEPTH) |=> $stable(wp_q);
	endproperty
	a_full_drop: assert property (p_full_drop) else $error("full queue accepted entry");

	property p_isum_refused;
		@(posedge clk_i) disable iff (rst_i)
			req && wb_req_i.we && adr == A_ISUM_EN && !multi_q |=> $stable(isum_en_q);
	endproperty
	a_isum_refused: assert property (p_isum_refused) else $error("mask written in single mode");

	property p_legacy_block;
		@(posedge clk_i) disable iff (rst_i)
			legacy_q && req && adr == A_INST1_EN |=> $stable(inst1_en_q) ##1 legacy_q;
	endproperty
	a_legacy_block: assert property (p_legacy_block) else $error("standard write in legacy");

	property p_echo_hold;
		@(posedge clk_i) disable iff (rst_i)
			echo_act_q && !ctrl_q[F_ECHO] && !(rx_i.valid && rx_i.data == CH_TERM) |=> echo_act_q;
	endproperty
	a_echo_hold: assert property (p_echo_hold) else $error("echo stopped early");

	property p_prompt;
		@(posedge clk_i) disable iff (rst_i)
			s_prompt_req ##1 !fmt_pend_q && !echo_pend_q |=> tx_o.valid && tx_o.data == CH_PROMPT;
	endproperty
	a_prompt: assert property (p_prompt) else $error("prompt not sent");

	property p_inst_set;
		@(posedge clk_i) disable iff (rst_i)
			ch_hit[0] && inst1_en_q[1] && !soft_rst |=> inst1_q[1];
	endproperty
	a_inst_set: assert property (p_inst_set) else $error("summary bit not set");

	property p_irq;
		@(posedge clk_i) disable iff (rst_i) irq_o == |($past(stat_q) & $past(irq_en_q));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt level wrong");

endmodule

// File: iss_host.sv
`timescale 1ns/1ps
module iss_host
	import iss_pkg::*;
(
	input  wire logic      clk_i,
	input  wire logic      rst_i,
	input  wire iss_char_t tx_i,
	input  wire logic      slow_i,
	output logic           tx_ready_o,
	output iss_char_t      rx_o
);
	logic [7:0] got[$];
	logic       tog_q;

	initial rx_o = '{1'b0, 8'h55};

	// slow mode takes every other cycle, so held characters must wait
	assign tx_ready_o = !rst_i && (!slow_i || tog_q);

	always @(posedge clk_i)
	begin
		tog_q <= rst_i ? 1'b0 : ~tog_q;
		if (!rst_i && tx_i.valid === 1'b1 && tx_ready_o)
			got.push_back(tx_i.data);
	end

	////////////////////////////////////////////////////////////////////////
	task send(input logic [7:0] c);
		@(posedge clk_i);
		rx_o <= '{1'b1, c};
		@(posedge clk_i);
		// released line shows the inverse so stale data is never mistaken
		rx_o <= '{1'b0, ~c};
	endtask
endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
	import iss_pkg::*;
	typedef struct packed {
		logic        we;
		logic [7:0]  adr;
		logic [31:0] wd;
		logic [31:0] rexp;
	} iss_row_t;

	logic                 clk_i;
	logic                 rst_i;
	logic                 slow;
	logic                 ack;
	logic                 irq;
	logic [31:0]          dat;
	iss_wb_req_t          req;
	iss_char_t            tx;
	iss_char_t            rx;
	logic                 tx_ready;
	logic [NCH-1:0][QW-1:0] evt;
	logic [15:0]          baud_div;
	logic                 flow;
	logic                 echo;
	logic                 compat;
	logic                 multi;
	logic                 legacy;
	logic [4:0]           gpib;
	int                   n_mismatch = 0;
	int                   checked = 0;
	int                   rates[4] = '{RATE_19200, RATE_9600, RATE_4800, RATE_2400};
	iss_row_t             rows[11] = '{
		'{1'b1, A_CTRL, 32'h1, 32'h1},
		'{1'b1, A_INST1_EN, 32'h1234, 32'h1234},
		'{1'b1, A_SECOND_CHANNEL_GROUP_SUMMARY_EN, 32'h7ffe, 32'h7ffe},
		'{1'b1, A_GPIB, 32'h1, 32'h1},
		'{1'b1, A_GPIB, 32'h1e, 32'h1e},
		'{1'b1, A_GPIB, 32'h0, 32'h1e},
		'{1'b1, A_GPIB, 32'h1f, 32'h1e},
		'{1'b1, A_MULTI, 32'h1, 32'h1},
		'{1'b1, A_ISUM_EN, 32'hffff, 32'hffff},
		'{1'b0, A_VERS, 32'h0, {VERS_YEAR, VERS_REV}},
		'{1'b0, 8'hfc, 32'h0, 32'h0}
	};

	iss_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(dat), .wb_ack_o(ack),
		.ques_evt_i(evt), .rx_i(rx), .tx_o(tx), .tx_ready_i(tx_ready), .baud_div_o(baud_div),
		.flow_xon_o(flow), .echo_on_o(echo), .compat_o(compat), .multi_inst_o(multi),
		.legacy_lang_o(legacy), .gpib_addr_o(gpib), .irq_o(irq));
	iss_host host (.clk_i(clk_i), .rst_i(rst_i), .tx_i(tx), .slow_i(slow),
		.tx_ready_o(tx_ready), .rx_o(rx));

	////////////////////////////////////////////////////////////////////////
	task wrap_up;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk_i);
		req <= '{1'b1, 1'b1, we, 4'hf, a, d};
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			chk("wb_ack", 32'h1, 32'h0);
			wrap_up;
		end
		r = dat;
		req <= '0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		wb(1'b1, a, d, r);
	endtask

	task rc(input string s, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		wb(1'b0, a, 32'h0, r);
		chk(s, e, r);
	endtask

	// echo_on_o and irq_o lag the acked write by a cycle
	task settle;
		repeat (2) @(posedge clk_i);
		#1;
	endtask

	task pulse(input int ch, input logic [15:0] v);
		@(posedge clk_i);
		evt[ch] <= v;
		@(posedge clk_i);
		evt <= '0;
	endtask

	task wait_got(input int n);
		int k;
		k = 0;
		while (host.got.size() < n && k < 400)
		begin
			@(posedge clk_i);
			k++;
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	initial
	begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		wrap_up;
	end

	initial
	begin
		rst_i = 1'b1;
		req = '0;
		evt = '0;
		slow = 1'b0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		settle;
		chk("baud_rst", {16'h0, DIV_9600}, {16'h0, baud_div});
		chk("gpib_rst", {27'h0, GPIB_RST}, {27'h0, gpib});
		chk("multi_rst", 32'h0, {31'h0, multi});
		foreach (rows[i])
		begin
			if (rows[i].we)
				wr(rows[i].adr, rows[i].wd);
			rc("row", rows[i].adr, rows[i].rexp);
		end
		settle;
		chk("flow", 32'h1, {31'h0, flow});
		chk("gpib", 32'h1e, {27'h0, gpib});
		foreach (rates[i])
		begin
			wr(A_BAUD, rates[i]);
			settle;
			chk("baud_div", 32'(CLK_HZ / rates[i]), {16'h0, baud_div});
		end
		wr(A_BAUD, 32'd1200);
		settle;
		chk("baud_bad", {16'h0, DIV_2400}, {16'h0, baud_div});
		rc("err1", A_ERR, 32'hffffff22);
		rc("err2", A_ERR, 32'hffffff22);
		rc("err3", A_ERR, 32'hffffff20);
		rc("err_empty", A_ERR, 32'h0);
		wr(A_IRQ_EN, 32'h3);
		for (int i = 1; i <= 16; i++)
			wr(A_ERR, i);
		settle;
		chk("irq_on", 32'h1, {31'h0, irq});
		for (int i = 1; i <= 14; i++)
			rc("err_fifo", A_ERR, i);
		rc("err_ovf", A_ERR, 32'hfffffea2);
		rc("err_end", A_ERR, 32'h0);
		wr(A_IRQ_CLR, 32'h3);
		settle;
		chk("irq_clr", 32'h0, {31'h0, irq});
		wr(A_IRQ_EN, 32'h0);
		wr(A_ERR, 32'h5);
		settle;
		chk("irq_mask", 32'h0, {31'h0, irq});
		wr(A_IRQ_EN, 32'h1);
		settle;
		chk("irq_unmask", 32'h1, {31'h0, irq});
		rc("err5", A_ERR, 32'h5);
		wr(A_IRQ_CLR, 32'h7);
		wr(A_CHSEL, 32'h1);
		wr(A_ISUM_EN, 32'h2);
		wr(A_INST1_EN, 32'h2);
		pulse(0, 16'h0003);
		settle;
		rc("inst1", A_INST1, 32'h2);
		rc("isum", A_ISUM, 32'h2);
		rc("isum_clr", A_ISUM, 32'h0);
		wr(A_CHSEL, 32'd15);
		wr(A_ISUM_EN, 32'h1);
		pulse(14, 16'h0001);
		settle;
		rc("second_channel_group_summary", A_SECOND_CHANNEL_GROUP_SUMMARY, 32'h2);
		wr(A_MULTI, 32'h0);
		settle;
		chk("multi_off", 32'h0, {31'h0, multi});
		rc("isum_en_off", A_ISUM_EN, 32'h0);
		rc("err_cmd", A_ERR, 32'hffffff9c);
		wr(A_ISUM_EN, 32'h8);
		rc("err_cmd2", A_ERR, 32'hffffff9c);
		wr(A_CTRL, 32'h5);
		wr(A_SOFT_RST, 32'h1);
		settle;
		chk("echo_kept", 32'h1, {31'h0, echo});
		rc("ctrl_kept", A_CTRL, 32'h4);
		host.send(8'h61);
		wait_got(1);
		wr(A_CTRL, 32'h0);
		host.send(8'h62);
		host.send(CH_TERM);
		wait_got(3);
		settle;
		chk("echo_off", 32'h0, {31'h0, echo});
		host.send(8'h63);
		repeat (20) @(posedge clk_i);
		chk("echo_cnt", 32'd3, host.got.size());
		chk("echo_b", 32'h62, {24'h0, host.got[1]});
		host.got.delete();
		wr(A_CTRL, 32'h2);
		wr(A_CMD_DONE, 32'h0);
		wait_got(1);
		wr(A_CTRL, 32'h0);
		wr(A_CMD_DONE, 32'h0);
		repeat (30) @(posedge clk_i);
		chk("prompt_cnt", 32'd1, host.got.size());
		chk("prompt", {24'h0, CH_PROMPT}, {24'h0, host.got[0]});
		host.got.delete();
		slow <= 1'b1;
		wr(A_QUERY, {24'h0, A_GPIB});
		wait_got(3);
		chk("q_d1", 32'h33, {24'h0, host.got[0]});
		chk("q_d0", 32'h30, {24'h0, host.got[1]});
		chk("q_term", {24'h0, CH_TERM}, {24'h0, host.got[2]});
		slow <= 1'b0;
		wr(A_LANG, 32'h1);
		wr(A_GPIB, 32'h5);
		wr(A_INST1_EN, 32'h4);
		rc("gpib_legacy", A_GPIB, 32'h0);
		wr(A_LANG_RET, LANG_WORD);
		settle;
		chk("legacy_off", 32'h0, {31'h0, legacy});
		rc("gpib_back", A_GPIB, 32'h1e);
		rc("inst1en_back", A_INST1_EN, 32'h0);
		wr(A_CTRL, 32'h8);
		settle;
		chk("compat", 32'h1, {31'h0, compat});
		wrap_up;
	end
endmodule
